/* src/cmp_defines.svh */
// Purpose: constants for the comparator mode and input-select register bank
// Assumes: 8-bit special-function-register bus, synchronous active-high reset
// Notes:   offsets are the bus addresses of the two registers
//
// How it works
// R1: mode bit 7 reads 1, software writes 1
// R2: mode bit 6 reads 0, writes ignored
// R3: mode bits 3:2 read 00, writes dropped
// R4: bit 5 enables rising-edge interrupt request
// R5: bit 4 enables falling-edge interrupt request
// R6: bits 1:0 drive comparator response-time mode
// R7: negative select routes pin, touch, half, regulator, ground
// R8: positive select routes pin, touch, half, supply
// R9: half-supply divider on only while selected
// R10: comparator output feeds timer two/three capture
// R11: software sets comparator pins analog, skipped
// R12: software clears mode bits, sets latch, skip
// R13: edge flags set always, cleared by software
// R14: output synchronised, used for edges and state
// R15: request is flag-and-enable, either edge ORed
`ifndef CMP_DEFINES_SVH
`define CMP_DEFINES_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define CMP_MODE_ADDR    8'h9d
`define CMP_MUX_ADDR     8'h9f

// ---------------------------------------------------------------
// mode register fields and reset
// ---------------------------------------------------------------
`define CMP_MODE_RSVD_BIT 7
`define CMP_MODE_UNUSED_BIT 6
`define CMP_MODE_RIE_BIT  5
`define CMP_MODE_FIE_BIT  4
`define CMP_MODE_MD_HI    1
`define CMP_MODE_MD_LO    0
`define CMP_MODE_RSVD_VAL 1'b1
`define CMP_MODE_ZERO_VAL 1'b0
`define CMP_MODE_GAP_VAL  2'h0
`define CMP_MODE_RIE_RST  1'b0
`define CMP_MODE_FIE_RST  1'b0
`define CMP_MODE_MD_RST   2'h2

// ---------------------------------------------------------------
// input-select register fields and reset
// ---------------------------------------------------------------
`define CMP_MUX_NEG_HI   7
`define CMP_MUX_NEG_LO   4
`define CMP_MUX_POS_HI   3
`define CMP_MUX_POS_LO   0
`define CMP_MUX_NEG_RST  4'h4
`define CMP_MUX_POS_RST  4'h4

// ---------------------------------------------------------------
// bus answers
// ---------------------------------------------------------------
`define CMP_UNMAPPED_RD  8'h00

`endif

/* src/cmp_pkg.sv */
// Purpose: types for the comparator mode and input-select register bank
// Assumes: codes match the input-select register encoding
// Notes:   reserved codes are not members; decoders treat them as off
`default_nettype none

package cmp_pkg;

  typedef enum logic [3:0] {
    CMP_NEG_PIN   = 4'h4,
    CMP_NEG_TOUCH = 4'hc,
    CMP_NEG_HALF  = 4'hd,
    CMP_NEG_DREG  = 4'he,
    CMP_NEG_GND   = 4'hf
  } cmp_neg_sel_type;

  typedef enum logic [3:0] {
    CMP_POS_PIN   = 4'h4,
    CMP_POS_TOUCH = 4'hc,
    CMP_POS_HALF  = 4'hd,
    CMP_POS_VDD_A = 4'he,
    CMP_POS_VDD_B = 4'hf
  } cmp_pos_sel_type;

  typedef enum logic [1:0] {
    CMP_RESP_FAST = 2'h0,
    CMP_RESP_MID1 = 2'h1,
    CMP_RESP_MID2 = 2'h2,
    CMP_RESP_SLOW = 2'h3
  } cmp_resp_type;

endpackage

`default_nettype wire

/* src/cmp_edge.sv */
// Purpose: synchronise comparator output, detect edges, hold sticky flags
// Assumes: raw_in is asynchronous to clk
// Notes:   a clear in the same cycle as a new edge leaves the flag set
`timescale 1ns/1ps
`default_nettype none

module cmp_edge
  import cmp_pkg::*;
(
  input  wire logic clk,       // system clock
  input  wire logic rst,       // synchronous reset
  input  wire logic raw_in,    // raw comparator output
  input  wire logic rise_clr,  // clear rising flag
  input  wire logic fall_clr,  // clear falling flag
  output var  logic out_state, // latched output
  output var  logic rise_flag, // sticky rising flag
  output var  logic fall_flag  // sticky falling flag
);

  logic sync1_r;
  logic sync2_r;
  logic prev_r;
  logic rise_r;
  logic fall_r;
  logic rise_nxt;
  logic fall_nxt;

  // ---------------------------------------------------------------
  // next flag values
  // ---------------------------------------------------------------
  always_comb begin
    // set wins over clear so no edge is lost
    rise_nxt = (rise_r & ~rise_clr) | (sync2_r & ~prev_r);  // see R13
    fall_nxt = (fall_r & ~fall_clr) | (~sync2_r & prev_r);  // see R13
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r  <= 1'b0;
      rise_r  <= 1'b0;
      fall_r  <= 1'b0;
    end else begin
      sync1_r <= raw_in;   // see R14
      sync2_r <= sync1_r;  // see R14
      prev_r  <= sync2_r;
      rise_r  <= rise_nxt;
      fall_r  <= fall_nxt;
    end
  end

  assign out_state = prev_r;
  assign rise_flag = rise_r;
  assign fall_flag = fall_r;

endmodule

`default_nettype wire

/* src/cmp_ctrl.sv */
// Purpose: comparator mode and input-select registers with edge logic
// Assumes: one system clock; bus strobes are single-cycle and synchronous
// Notes:   read data is registered and valid the cycle after the strobe
`timescale 1ns/1ps
`default_nettype none

`include "cmp_defines.svh"

module cmp_ctrl
  import cmp_pkg::*;
(
  input  wire logic       clk,          // system clock, 125 MHz
  input  wire logic       rst,          // synchronous reset
  input  wire logic [7:0] sfr_addr,     // register address
  input  wire logic       sfr_wr,       // write strobe
  input  wire logic       sfr_rd,       // read strobe
  input  wire logic [7:0] sfr_wdata,    // write data
  output var  logic [7:0] sfr_rdata,    // read data
  input  wire logic       cmp_raw,      // raw comparator output
  input  wire logic       rise_clr,     // software clear of rising flag
  input  wire logic       fall_clr,     // software clear of falling flag
  output var  logic       cmp_out,      // latched comparator output
  output var  logic       rise_edge_flag, // rising-edge flag
  output var  logic       fall_edge_flag, // falling-edge flag
  output var  logic       cmp_irq,      // interrupt request
  output var  logic [1:0] response_mode,  // response-time setting
  output var  logic       neg_pin,      // negative input on pin two
  output var  logic       neg_touch,    // negative input on touch ref
  output var  logic       neg_half,     // negative input on half supply
  output var  logic       neg_dreg,     // negative input on regulator
  output var  logic       neg_gnd,      // negative input on ground
  output var  logic       pos_pin,      // positive input on pin one
  output var  logic       pos_touch,    // positive input on touch ref
  output var  logic       pos_half,     // positive input on half supply
  output var  logic       pos_vdd,      // positive input on supply
  output var  logic       half_div_en,  // half-supply divider enable
  output var  logic       t2_capture,   // capture input to timer two
  output var  logic       t3_capture    // capture input to timer three
);

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic       rise_ie_r;
  logic       rise_ie_nxt;
  logic       fall_ie_r;
  logic       fall_ie_nxt;
  logic [1:0] mode_r;
  logic [1:0] mode_nxt;
  logic [3:0] neg_sel_r;
  logic [3:0] neg_sel_nxt;
  logic [3:0] pos_sel_r;
  logic [3:0] pos_sel_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [7:0] mode_view;
  logic [7:0] mux_view;

  // ---------------------------------------------------------------
  // derived output state
  // ---------------------------------------------------------------
  logic       irq_r;
  logic       irq_nxt;
  logic [1:0] resp_r;
  logic [1:0] resp_nxt;
  logic [4:0] neg_route_r;
  logic [4:0] neg_route_nxt;
  logic [3:0] pos_route_r;
  logic [3:0] pos_route_nxt;
  logic       half_r;
  logic       half_nxt;
  logic       t2_r;
  logic       t2_nxt;
  logic       t3_r;
  logic       t3_nxt;

  // ---------------------------------------------------------------
  // edge path
  // ---------------------------------------------------------------
  logic       out_state;
  logic       rise_flag;
  logic       fall_flag;

  cmp_edge u_edge (
    .clk       (clk),
    .rst       (rst),
    .raw_in    (cmp_raw),
    .rise_clr  (rise_clr),
    .fall_clr  (fall_clr),
    .out_state (out_state),
    .rise_flag (rise_flag),
    .fall_flag (fall_flag)
  );

  // ---------------------------------------------------------------
  // register read views
  // ---------------------------------------------------------------
  always_comb begin
    mode_view                        = 8'h00;
    mode_view[`CMP_MODE_RSVD_BIT]    = `CMP_MODE_RSVD_VAL;   // see R1
    mode_view[`CMP_MODE_UNUSED_BIT]  = `CMP_MODE_ZERO_VAL;   // see R2
    mode_view[`CMP_MODE_RIE_BIT]     = rise_ie_r;
    mode_view[`CMP_MODE_FIE_BIT]     = fall_ie_r;
    mode_view[3:2]                   = `CMP_MODE_GAP_VAL;    // see R3
    mode_view[`CMP_MODE_MD_HI:`CMP_MODE_MD_LO] = mode_r;
    mux_view = {neg_sel_r, pos_sel_r};
  end

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  // bit 7 holds no storage: it always reads back 1, so a careless
  // write of 0 cannot disturb the block
  always_comb begin
    rise_ie_nxt = rise_ie_r;
    fall_ie_nxt = fall_ie_r;
    mode_nxt    = mode_r;
    neg_sel_nxt = neg_sel_r;
    pos_sel_nxt = pos_sel_r;
    if (sfr_wr) begin
      if (sfr_addr == `CMP_MODE_ADDR) begin
        // bits 7, 6, 3 and 2 are dropped here
        rise_ie_nxt = sfr_wdata[`CMP_MODE_RIE_BIT];          // see R4
        fall_ie_nxt = sfr_wdata[`CMP_MODE_FIE_BIT];          // see R5
        mode_nxt    = sfr_wdata[`CMP_MODE_MD_HI:`CMP_MODE_MD_LO];  // see R6
      end
      if (sfr_addr == `CMP_MUX_ADDR) begin
        neg_sel_nxt = sfr_wdata[`CMP_MUX_NEG_HI:`CMP_MUX_NEG_LO];
        pos_sel_nxt = sfr_wdata[`CMP_MUX_POS_HI:`CMP_MUX_POS_LO];
      end
    end
  end

  // ---------------------------------------------------------------
  // register reads
  // ---------------------------------------------------------------
  always_comb begin
    rdata_nxt = rdata_r;
    if (sfr_rd) begin
      unique case (sfr_addr)
        `CMP_MODE_ADDR: begin
          rdata_nxt = mode_view;
        end
        `CMP_MUX_ADDR: begin
          rdata_nxt = mux_view;
        end
        default: begin
          rdata_nxt = `CMP_UNMAPPED_RD;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rise_ie_r <= `CMP_MODE_RIE_RST;
      fall_ie_r <= `CMP_MODE_FIE_RST;
      mode_r    <= `CMP_MODE_MD_RST;
      neg_sel_r <= `CMP_MUX_NEG_RST;
      pos_sel_r <= `CMP_MUX_POS_RST;
    end else begin
      rise_ie_r <= rise_ie_nxt;
      fall_ie_r <= fall_ie_nxt;
      mode_r    <= mode_nxt;
      neg_sel_r <= neg_sel_nxt;
      pos_sel_r <= pos_sel_nxt;
    end
  end

  // read data is held between strobes, so a slow reader sees a
  // stable byte until it asks again
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ---------------------------------------------------------------
  // negative input routing
  // ---------------------------------------------------------------
  // reserved codes leave every switch open, so no path is shorted
  always_comb begin
    neg_route_nxt = 5'h00;
    unique case (neg_sel_r)
      CMP_NEG_PIN: begin
        neg_route_nxt[0] = 1'b1;   // see R7
      end
      CMP_NEG_TOUCH: begin
        neg_route_nxt[1] = 1'b1;   // see R7
      end
      CMP_NEG_HALF: begin
        neg_route_nxt[2] = 1'b1;   // see R7
      end
      CMP_NEG_DREG: begin
        neg_route_nxt[3] = 1'b1;   // see R7
      end
      CMP_NEG_GND: begin
        neg_route_nxt[4] = 1'b1;   // see R7
      end
      default: begin
        neg_route_nxt = 5'h00;
      end
    endcase
  end

  // one flop per switch, so a decode glitch never closes two
  // switches at once
  always_ff @(posedge clk) begin
    if (rst) begin
      neg_route_r <= 5'h00;
    end else begin
      neg_route_r <= neg_route_nxt;
    end
  end

  // ---------------------------------------------------------------
  // positive input routing
  // ---------------------------------------------------------------
  always_comb begin
    pos_route_nxt = 4'h0;
    unique case (pos_sel_r)
      CMP_POS_PIN: begin
        pos_route_nxt[0] = 1'b1;   // see R8
      end
      CMP_POS_TOUCH: begin
        pos_route_nxt[1] = 1'b1;   // see R8
      end
      CMP_POS_HALF: begin
        pos_route_nxt[2] = 1'b1;   // see R8
      end
      CMP_POS_VDD_A, CMP_POS_VDD_B: begin
        pos_route_nxt[3] = 1'b1;   // see R8
      end
      default: begin
        pos_route_nxt = 4'h0;
      end
    endcase
  end

  // registered like the negative side, so both inputs switch on
  // the same edge
  always_ff @(posedge clk) begin
    if (rst) begin
      pos_route_r <= 4'h0;
    end else begin
      pos_route_r <= pos_route_nxt;
    end
  end

  // ---------------------------------------------------------------
  // divider, mode, capture and request
  // ---------------------------------------------------------------
  // divider draws current, so it runs only while some side uses it
  always_comb begin
    half_nxt = neg_route_nxt[2] | pos_route_nxt[2];           // see R9
    resp_nxt = mode_r;                                          // see R6
    t2_nxt   = out_state;                                       // see R10
    t3_nxt   = out_state;                                       // see R10
    irq_nxt  = (rise_flag & rise_ie_r) | (fall_flag & fall_ie_r);  // see R15 R4 R5
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      half_r      <= 1'b0;
      resp_r      <= `CMP_MODE_MD_RST;
      t2_r        <= 1'b0;
      t3_r        <= 1'b0;
      irq_r       <= 1'b0;
    end else begin
      half_r      <= half_nxt;
      resp_r      <= resp_nxt;
      t2_r        <= t2_nxt;
      t3_r        <= t3_nxt;
      irq_r       <= irq_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign sfr_rdata      = rdata_r;
  assign cmp_out        = out_state;   // see R14
  assign rise_edge_flag = rise_flag;
  assign fall_edge_flag = fall_flag;
  assign cmp_irq        = irq_r;
  assign response_mode  = resp_r;
  assign neg_pin        = neg_route_r[0];
  assign neg_touch      = neg_route_r[1];
  assign neg_half       = neg_route_r[2];
  assign neg_dreg       = neg_route_r[3];
  assign neg_gnd        = neg_route_r[4];
  assign pos_pin        = pos_route_r[0];
  assign pos_touch      = pos_route_r[1];
  assign pos_half       = pos_route_r[2];
  assign pos_vdd        = pos_route_r[3];
  assign half_div_en    = half_r;
  assign t2_capture     = t2_r;
  assign t3_capture     = t3_r;

endmodule

`default_nettype wire

/* bench/cmp_ctrl_props.sv */
// Purpose: port-level checks for the comparator mode and input-select bank
// Assumes: one clock, synchronous active-high reset, registered outputs
// Notes:   bound to every cmp_ctrl instance below
`timescale 1ns/1ps
`default_nettype none

module cmp_ctrl_props
  import cmp_pkg::*;
(
  input wire logic       clk,            // clock
  input wire logic       rst,            // reset
  input wire logic [7:0] sfr_addr,       // address
  input wire logic       sfr_wr,         // write strobe
  input wire logic       sfr_rd,         // read strobe
  input wire logic [7:0] sfr_wdata,      // write data
  input wire logic [7:0] sfr_rdata,      // read data
  input wire logic       cmp_raw,        // raw output
  input wire logic       rise_clr,       // rise clear
  input wire logic       fall_clr,       // fall clear
  input wire logic       cmp_out,        // latched output
  input wire logic       rise_edge_flag, // rise flag
  input wire logic       fall_edge_flag, // fall flag
  input wire logic       cmp_irq,        // request
  input wire logic [1:0] response_mode,  // mode
  input wire logic       neg_pin,        // neg pin
  input wire logic       neg_touch,      // neg touch
  input wire logic       neg_half,       // neg half
  input wire logic       neg_dreg,       // neg regulator
  input wire logic       neg_gnd,        // neg ground
  input wire logic       pos_pin,        // pos pin
  input wire logic       pos_touch,      // pos touch
  input wire logic       pos_half,       // pos half
  input wire logic       pos_vdd,        // pos supply
  input wire logic       half_div_en,    // divider
  input wire logic       t2_capture,     // timer two
  input wire logic       t3_capture      // timer three
);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  // slices as plain signals so that $past sees a signal
  logic [1:0] wd_mode;
  logic [3:0] wd_neg;
  logic [3:0] wd_pos;
  assign wd_mode = sfr_wdata[1:0];
  assign wd_neg  = sfr_wdata[7:4];
  assign wd_pos  = sfr_wdata[3:0];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_mode_read: assert property (
    sfr_rd && sfr_addr == 8'h9d |=> sfr_rdata[7:6] == 2'h2 && sfr_rdata[3:2] == 2'h0)
    else $error("mode read shows wrong fixed bits");
  a_unmapped_read: assert property (
    sfr_rd && sfr_addr != 8'h9d && sfr_addr != 8'h9f |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_mode_drive: assert property (
    sfr_wr && sfr_addr == 8'h9d ##2 1'b1 |-> response_mode == $past(wd_mode, 2))
    else $error("response mode not driven from write");
  a_neg_route: assert property (
    sfr_wr && sfr_addr == 8'h9f ##2 1'b1 |->
      neg_half == ($past(wd_neg, 2) == 4'hd) && neg_gnd == ($past(wd_neg, 2) == 4'hf))
    else $error("negative routing wrong");
  a_pos_route: assert property (
    sfr_wr && sfr_addr == 8'h9f ##2 1'b1 |->
      pos_vdd == ($past(wd_pos, 2) >= 4'he) && pos_pin == ($past(wd_pos, 2) == 4'h4))
    else $error("positive routing wrong");
  a_half_div: assert property (
    half_div_en == (neg_half || pos_half)) else $error("divider enable wrong");
  a_rise_set: assert property (
    $rose(cmp_out) |-> rise_edge_flag) else $error("rising flag not set");
  a_fall_set: assert property (
    $fell(cmp_out) |-> fall_edge_flag) else $error("falling flag not set");
  a_rise_sticky: assert property (
    rise_edge_flag && !rise_clr |=> rise_edge_flag) else $error("rising flag lost");
  a_fall_clear: assert property (
    fall_clr ##1 !$fell(cmp_out) |-> !fall_edge_flag) else $error("falling flag not cleared");
  a_sync_delay: assert property (
    !$past(rst) && !$past(rst, 2) && !$past(rst, 3) |-> cmp_out == $past(cmp_raw, 3))
    else $error("latched output delay wrong");
  a_capture_copy: assert property (
    t2_capture == $past(cmp_out) && t3_capture == t2_capture) else $error("capture wrong");
  a_irq_cause: assert property (
    cmp_irq |-> $past(rise_edge_flag) || $past(fall_edge_flag)) else $error("stray request");
  a_irq_quiet: assert property (
    !rise_edge_flag && !fall_edge_flag |=> !cmp_irq) else $error("request without flag");

  c_irq: cover property ($rose(cmp_irq));
  c_half: cover property (half_div_en);
  c_mux_read: cover property (sfr_rd && sfr_addr == 8'h9f);
endmodule

bind cmp_ctrl cmp_ctrl_props i_props (
  .clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .cmp_raw(cmp_raw), .rise_clr(rise_clr),
  .fall_clr(fall_clr), .cmp_out(cmp_out), .rise_edge_flag(rise_edge_flag),
  .fall_edge_flag(fall_edge_flag), .cmp_irq(cmp_irq), .response_mode(response_mode),
  .neg_pin(neg_pin), .neg_touch(neg_touch), .neg_half(neg_half), .neg_dreg(neg_dreg),
  .neg_gnd(neg_gnd), .pos_pin(pos_pin), .pos_touch(pos_touch), .pos_half(pos_half),
  .pos_vdd(pos_vdd), .half_div_en(half_div_en), .t2_capture(t2_capture),
  .t3_capture(t3_capture)
);

`default_nettype wire

/* bench/cmp_ctrl_bench.sv */
// Purpose: self-checking bench for the comparator mode and input-select bank
// Assumes: inputs driven at the falling edge, read data valid one cycle later
// Notes:   expected register views come from a small integer model
`timescale 1ns/1ps
`default_nettype none

module cmp_ctrl_bench;
  logic       clk = 1'b0, rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0;
  logic       cmp_raw = 1'b0, rise_clr = 1'b0, fall_clr = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
  logic       cmp_out, rise_edge_flag, fall_edge_flag, cmp_irq, half_div_en;
  logic [1:0] response_mode;
  logic       neg_pin, neg_touch, neg_half, neg_dreg, neg_gnd, t2_capture, t3_capture;
  logic       pos_pin, pos_touch, pos_half, pos_vdd;
  logic [8:0] rt_seen;
  int         errors = 0, check_count = 0, mode_m, d;
  int         exp_q[$];

  always #4 clk = ~clk;
  assign rt_seen = {neg_pin, neg_touch, neg_half, neg_dreg, neg_gnd,
                    pos_pin, pos_touch, pos_half, pos_vdd};

  cmp_ctrl i_dut (
    .clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .cmp_raw(cmp_raw), .rise_clr(rise_clr),
    .fall_clr(fall_clr), .cmp_out(cmp_out), .rise_edge_flag(rise_edge_flag),
    .fall_edge_flag(fall_edge_flag), .cmp_irq(cmp_irq), .response_mode(response_mode),
    .neg_pin(neg_pin), .neg_touch(neg_touch), .neg_half(neg_half), .neg_dreg(neg_dreg),
    .neg_gnd(neg_gnd), .pos_pin(pos_pin), .pos_touch(pos_touch), .pos_half(pos_half),
    .pos_vdd(pos_vdd), .half_div_en(half_div_en), .t2_capture(t2_capture),
    .t3_capture(t3_capture)
  );

  // ---------------------------------------------------------------
  // tasks and model
  // ---------------------------------------------------------------
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    chk({1'b0, sfr_rdata}, {1'b0, exp});
  endtask

  // set wins over clear, so clears are kept away from raw changes
  task automatic clr(input logic r, input logic f);
    @(negedge clk);
    rise_clr = r;
    fall_clr = f;
    @(negedge clk);
    rise_clr = 1'b0;
    fall_clr = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  function automatic logic [8:0] route(input logic [7:0] m);
    return {m[7:4] == 4'h4, m[7:4] == 4'hc, m[7:4] == 4'hd, m[7:4] == 4'he, m[7:4] == 4'hf,
            m[3:0] == 4'h4, m[3:0] == 4'hc, m[3:0] == 4'hd, m[3:0] >= 4'he};
  endfunction

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'h07ba));
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rd(8'h9d, 8'h82);
    rd(8'h9f, 8'h44);
    chk({7'h00, response_mode}, 9'h002);
    chk(rt_seen, route(8'h44));
    for (int i = 0; i < 4; i++) begin
      d = ($urandom & 8'h7c) | 8'h80 | i;
      wr(8'h9d, 8'(d));
      mode_m = (d & 8'h33) | 8'h80;
      rd(8'h9d, 8'(mode_m));
      chk({7'h00, response_mode}, 9'(i));
    end
    for (int i = 0; i < 16; i++) begin
      d = (i << 4) | (15 - i);
      exp_q.push_back(d);
      wr(8'h9f, 8'(d));
      rd(8'h9f, 8'(exp_q.pop_front()));
      chk(rt_seen, route(8'(d)));
      chk({8'h00, half_div_en}, 9'(i == 13 || i == 2));
    end
    // unmapped write must leave the mode register alone
    wr(8'h9e, 8'hff);
    rd(8'h9e, 8'h00);
    rd(8'h9d, 8'(mode_m));
    for (int e = 0; e < 4; e++) begin
      wr(8'h9d, 8'(8'h80 | (e << 4)));
      clr(1'b1, 1'b1);
      cmp_raw = 1'b1; // pins set analog, routing skips them
      repeat (6) @(negedge clk);
      chk({6'h00, cmp_out, t2_capture, t3_capture}, 9'h007);
      chk({7'h00, rise_edge_flag, fall_edge_flag}, 9'h002);
      chk({8'h00, cmp_irq}, 9'(e >> 1));
      cmp_raw = 1'b0;
      repeat (6) @(negedge clk);
      chk({6'h00, cmp_out, t2_capture, t3_capture}, 9'h000);
      chk({7'h00, rise_edge_flag, fall_edge_flag}, 9'h003);
      chk({8'h00, cmp_irq}, 9'(e != 0));
      clr(1'b1, 1'b0);
      chk({7'h00, rise_edge_flag, fall_edge_flag}, 9'h001);
      chk({8'h00, cmp_irq}, 9'(e & 1));
    end
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rd(8'h9d, 8'h82);
    rd(8'h9f, 8'h44);
    chk({7'h00, rise_edge_flag, fall_edge_flag}, 9'h000);
    conclude();
  end

  // whole run is well under a thousand cycles
  initial begin
    #200000;
    errors++;
    conclude();
  end
endmodule

`default_nettype wire
